/* File: design/wdt_access_pkg.sv */
// Package of constants and carriers for the keyed watchdog register access block
package wdt_access_pkg;

    // Access sizes on the peripheral write port
    typedef enum logic [1:0] {
        size_byte = 2'h0,
        size_word = 2'h1,
        size_long = 2'h2
    } access_size_t;

    // Register selection
    typedef enum logic [1:0] {
        sel_count   = 2'h0,
        sel_control = 2'h1,
        sel_resetc  = 2'h2,
        sel_none    = 2'h3
    } reg_sel_t;

    localparam logic [7:0] count_key      = 8'h5a;
    localparam logic [7:0] control_key    = 8'ha5;
    localparam logic [7:0] count_reset    = 8'h00;
    localparam logic [7:0] control_reset  = 8'h00;
    localparam int         reset_sel_bit  = 5;
    localparam logic [4:0] reserved_ones  = 5'h1f;
    localparam logic       reset_sel_init = 1'b0;

    typedef struct packed {
        logic         valid;
        reg_sel_t     sel;
        access_size_t size;
        logic [15:0]  data;
    } write_req_t;

    typedef struct packed {
        logic power_on;
        logic manual;
    } reset_req_t;

endpackage

/* File: design/wdt_keyed_access.sv */
// Keyed write filter, register store and reset type selection for the watchdog
`timescale 1ns/1ps
module wdt_keyed_access
    import wdt_access_pkg::*;
#(
    // Register and key widths
    parameter int reg_w = 8,
    parameter int key_w = 8
)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Write port from the peripheral bus
    input  wire write_req_t   wr,
    // Read port
    input  wire reg_sel_t     rd_sel,
    output logic [reg_w-1:0]  rd_data,
    // Register contents toward the counting logic
    output logic [reg_w-1:0]  wdt_count_reg,
    output logic [reg_w-1:0]  wdt_control_status_reg,
    // Overflow from the counting logic and its mode
    input  wire logic         overflow,
    input  wire logic         watchdog_mode,
    // Reset requests
    output reset_req_t        reset_req
);

    // Data field width of the write carrier
    localparam int bus_w = $bits(write_req_t) - $bits(reg_sel_t) - $bits(access_size_t) - 1;
    // Width of the always-one field below the select bit
    localparam int rsv_w = $bits(reserved_ones);
    // Read image of the reset control register straight after reset
    localparam logic [7:0] resetc_init = {2'h0, reset_sel_init, reserved_ones};

    // Key byte and data byte must split the carrier word exactly
    if (key_w != $bits(count_key) || reg_w + key_w != bus_w) begin : g_bad_width
        $error("wdt_keyed_access: key_w and reg_w must split the write data word");
    end

    // Select bit must lie above the reserved field, inside the register
    if (reset_sel_bit < rsv_w || reset_sel_bit >= reg_w) begin : g_bad_select
        $error("wdt_keyed_access: reset type select bit outside the register");
    end

    // Decoded write request
    logic                word_ok;
    logic                hit_count;
    logic                hit_control;
    logic                hit_resetc;
    logic [key_w-1:0]    wr_key;
    logic [reg_w-1:0]    wr_low;
    logic                key_needed;
    logic [key_w-1:0]    expected_key;
    logic                key_ok;
    logic                load_count;
    logic                load_control;
    logic                load_resetc;

    // Reset type select and read path
    logic                reset_type_select;
    logic [reg_w-1:0]    resetc_image;
    logic [reg_w-1:0]    next_rd_data;

    // Overflow qualification and requests
    logic                wd_overflow;
    logic                next_power_on;
    logic                next_manual;
    logic                power_on_req;
    logic                manual_req;

    // Key byte rides in the upper half, data byte in the lower half
    assign wr_key = wr.data[bus_w-1:reg_w];
    assign wr_low = wr.data[reg_w-1:0];

    assign word_ok = wr.valid && (wr.size == size_word);

    // Target decode; an unmapped select writes nothing
    always_comb begin
        hit_count   = 1'b0;
        hit_control = 1'b0;
        hit_resetc  = 1'b0;
        unique case (wr.sel)
            sel_count: begin
                hit_count = word_ok;
            end
            sel_control: begin
                hit_control = word_ok;
            end
            sel_resetc: begin
                hit_resetc = word_ok;
            end
            default: begin
                hit_count = 1'b0;
            end
        endcase
    end

    always_comb begin
        key_needed   = 1'b0;
        expected_key = '0;
        unique case (wr.sel)
            sel_count: begin
                key_needed   = 1'b1;
                expected_key = count_key;
            end
            sel_control: begin
                key_needed   = 1'b1;
                expected_key = control_key;
            end
            default: begin
                // Reset control write procedure is not modelled, so no key
                key_needed = 1'b0;
            end
        endcase
    end

    // key must match where one is required
    assign key_ok = !key_needed || (wr_key == expected_key);

    assign load_count   = hit_count && key_ok;
    assign load_control = hit_control && key_ok;
    assign load_resetc  = hit_resetc && key_ok;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_count_reg <= count_reset;
        end else if (load_count) begin
            wdt_count_reg <= wr_low;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_control_status_reg <= control_reset;
        end else if (load_control) begin
            wdt_control_status_reg <= wr_low;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reset_type_select <= reset_sel_init;
        end else if (load_resetc) begin
            reset_type_select <= wr.data[reset_sel_bit];
        end
    end

    for (genvar b = 0; b < reg_w; b++) begin : g_resetc_bit
        if (b < rsv_w) begin : g_reserved
            assign resetc_image[b] = reserved_ones[b];
        end else if (b == reset_sel_bit) begin : g_select
            assign resetc_image[b] = reset_type_select;
        end else begin : g_upper
            // Bits above the select bit are unused here and read as zero
            assign resetc_image[b] = 1'b0;
        end
    end

    // Read source selection
    always_comb begin
        next_rd_data = '0;
        unique case (rd_sel)
            sel_count: begin
                next_rd_data = wdt_count_reg;
            end
            sel_control: begin
                next_rd_data = wdt_control_status_reg;
            end
            sel_resetc: begin
                next_rd_data = resetc_image;
            end
            default: begin
                next_rd_data = '0;
            end
        endcase
    end

    // Registered read data: a read shows one clock after its select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= resetc_init;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    assign wd_overflow = overflow && watchdog_mode;

    assign next_power_on = wd_overflow && !reset_type_select;
    assign next_manual   = wd_overflow && reset_type_select;

    // Power-on request, one pulse per overflow cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_on_req <= 1'b0;
        end else begin
            power_on_req <= next_power_on;
        end
    end

    // Manual request, one pulse per overflow cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            manual_req <= 1'b0;
        end else begin
            manual_req <= next_manual;
        end
    end

    // Exclusive by construction: both come from the one select bit
    assign reset_req = '{power_on: power_on_req, manual: manual_req};

endmodule

/* File: verif/wdt_access_asserts.sv */
// Checker for the keyed watchdog access block
`timescale 1ns/1ps
module wdt_access_chk import wdt_access_pkg::*; (
    // Watched ports
    input wire logic       clk, rst, overflow, watchdog_mode,
    input wire write_req_t wr,
    input wire reg_sel_t   rd_sel,
    input wire logic [7:0] rd_data, wdt_count_reg, wdt_control_status_reg,
    input wire reset_req_t reset_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire key = wr.valid && wr.size == size_word && wr.sel == sel_count;
    wire ckey = wr.valid && wr.size == size_word && wr.sel == sel_control;
    a_wd_reset: assert property (overflow && watchdog_mode |=> ^reset_req)
        else $error("no reset");
    a_int_quiet: assert property (!watchdog_mode |=> reset_req == 0)
        else $error("reset");
    a_rsv_ones: assert property (rd_sel == sel_resetc |=> &rd_data[4:0])
        else $error("reserved");
    a_cnt_load: assert property (key && wr.data[15:8] == count_key
        |=> wdt_count_reg == $past(wr.data[7:0])) else $error("load");
    a_cnt_guard: assert property (!key || wr.data[15:8] != count_key
        |=> $stable(wdt_count_reg)) else $error("guard");
    a_ctl_load: assert property (ckey && wr.data[15:8] == control_key
        |=> wdt_control_status_reg == $past(wr.data[7:0])) else $error("control load");
    a_ctl_guard: assert property (!ckey || wr.data[15:8] != control_key
        |=> $stable(wdt_control_status_reg)) else $error("control guard");
endmodule
bind wdt_keyed_access wdt_access_chk u_chk (.clk, .rst, .overflow, .watchdog_mode, .wr,
    .rd_sel, .rd_data, .wdt_count_reg, .wdt_control_status_reg, .reset_req);

/* File: verif/testbench.sv */
// Testbench for the keyed watchdog access block
`timescale 1ns/1ps
module testbench;
    import wdt_access_pkg::*;
    logic       clk = 0, rst = 1, overflow = 0, watchdog_mode = 0;
    write_req_t wr = '0;
    reg_sel_t   rd_sel = sel_resetc;
    logic [7:0] rd_data, cnt, ctl;
    reset_req_t req;
    int         miscompares = 0, n_compared = 0;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
    $display("Error %0t %h %h", $time, a, b); end end
    wdt_keyed_access u_dut (.clk, .rst, .wr, .rd_sel, .rd_data, .wdt_count_reg(cnt),
        .wdt_control_status_reg(ctl), .overflow, .watchdog_mode, .reset_req(req));
    initial forever #12.5 clk = ~clk;
    task w(reg_sel_t s, access_size_t z, logic [15:0] d);
        @(posedge clk) wr <= '{1'b1, s, z, d};
        @(posedge clk) wr.valid <= 1'b0;
        #1;
    endtask
    task rd(reg_sel_t s);
        @(posedge clk) rd_sel <= s;
        @(posedge clk) #1;
    endtask
    task t_writes;
        w(sel_count, size_word, 16'h5a33); `CHK(cnt, 8'h33)
        w(sel_control, size_word, 16'ha5c4); `CHK(ctl, 8'hc4)
        w(sel_count, size_byte, 16'h5a11);
        w(sel_control, size_long, 16'ha511); `CHK({cnt, ctl}, 16'h33c4)
        w(sel_count, size_word, 16'ha577);
        w(sel_control, size_word, 16'h5a77); `CHK({cnt, ctl}, 16'h33c4)
        rd(sel_count); `CHK(rd_data, 8'h33)
        rd(sel_control); `CHK(rd_data, 8'hc4)
        $display("writes done");
    endtask
    // Last two passes run interval mode, where no reset may follow
    task t_reset;
        for (int i = 0; i < 4; i++) begin
            w(sel_resetc, size_word, {10'h0, i[0], 5'h1f});
            rd(sel_resetc); `CHK(rd_data, {2'h0, i[0], 5'h1f})
            @(posedge clk) begin overflow <= 1'b1; watchdog_mode <= i < 2; end
            @(posedge clk) overflow <= 1'b0;
            #1 `CHK(req, i >= 2 ? 2'b00 : {~i[0], i[0]})
        end
        $display("reset select done");
    endtask
    task close_out;
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        `CHK({rd_data, cnt, ctl}, 24'h1f0000)
        rst <= 1'b0;
        t_writes;
        t_reset;
        close_out;
    end
endmodule
